// ---- rtl/data_flash_access_gate.sv ----
// Data flash access gate: setup timing, read gating, STOP blocking, DMA hold
//
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module data_flash_access_gate
  import dflash_gate_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic                    reset,
  input  wire logic [3:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  output logic      [31:0]             avs_readdata,
  output logic                         avs_waitrequest,
  input  wire logic                    cpu_flash_read,
  input  wire logic                    cpu_flash_store,
  input  wire logic                    stop_request,
  output logic                         flash_read_grant,
  output logic                         flash_store_blocked,
  output logic                         stop_accept,
  output logic [DMA_CHANNELS-1:0]      dma_channel_hold_bit
);
  avl_req_t                req;
  logic                    flash_array_enable_bit_q;
  flash_mode_t             mode_q;
  array_state_t            state_q;
  logic [CNT_W-1:0]        setup_cnt_q;
  logic [1:0]              hold_cnt_q;
  logic                    ack_q;
  logic                    wr_en;
  logic                    en_d;
  logic [CNT_W-1:0]        load_cnt;
  logic [CNT_W-1:0]        setup_len_q;
  flash_mode_t             setup_mode_q;

  assign req = '{read: avs_read, write: avs_write, address: avs_address,
                 writedata: avs_writedata};
  // One wait state per access keeps read data registered
  // Writes commit only at the edge where the master sees waitrequest low
  assign wr_en = req.write && ack_q;
  assign en_d  = (wr_en && req.address == CTRL_ADDR) ? req.writedata[ENABLE_BIT]
                                                     : flash_array_enable_bit_q;

  always_comb begin
    unique case (mode_q)
      high_speed_main_mode:  load_cnt = CNT_W'(SETUP_HS_CYC);
      low_speed_main_mode:   load_cnt = CNT_W'(SETUP_LS_CYC);
      low_voltage_main_mode: load_cnt = CNT_W'(SETUP_LV_CYC);
      default:               load_cnt = CNT_W'(SETUP_LV_CYC);
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (req.read || req.write) && !ack_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((req.read || req.write) && !ack_q);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flash_array_enable_bit_q <= 1'b0;
      mode_q                   <= high_speed_main_mode;
      dma_channel_hold_bit     <= '0;
    end else if (wr_en) begin
      unique case (req.address)
        CTRL_ADDR: flash_array_enable_bit_q <= req.writedata[ENABLE_BIT];
        MODE_ADDR:
          if (req.writedata[1:0] != 2'h3)
            mode_q <= flash_mode_t'(req.writedata[1:0]);
        HOLD_ADDR: dma_channel_hold_bit <= req.writedata[DMA_CHANNELS-1:0];
        default: ;
      endcase
    end
  end

  // Mode changes during setup only affect the next enable
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q     <= ARRAY_STOPPED;
      setup_cnt_q <= '0;
    end else if (!en_d) begin
      state_q     <= ARRAY_STOPPED;
      setup_cnt_q <= '0;
    end else begin
      unique case (state_q)
        ARRAY_STOPPED: begin
          state_q     <= ARRAY_SETUP;
          setup_cnt_q <= load_cnt;
        end
        ARRAY_SETUP: begin
          if (setup_cnt_q <= CNT_W'(1)) begin
            state_q     <= ARRAY_READY;
            setup_cnt_q <= '0;
          end else begin
            setup_cnt_q <= setup_cnt_q - CNT_W'(1);
          end
        end
        ARRAY_READY: ;
      endcase
    end
  end

  // Counts clocks since the hold register was last written, saturating
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      hold_cnt_q <= HOLD_CNT_W0;
    end else if (wr_en && req.address == HOLD_ADDR) begin
      hold_cnt_q <= HOLD_CNT_W0;
    end else if (hold_cnt_q != 2'(HOLD_WAIT)) begin
      hold_cnt_q <= hold_cnt_q + 2'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flash_read_grant    <= 1'b0;
      flash_store_blocked <= 1'b0;
      stop_accept         <= 1'b0;
    end else begin
      flash_read_grant    <= cpu_flash_read && state_q == ARRAY_READY;
      flash_store_blocked <= cpu_flash_store;
      stop_accept         <= stop_request && state_q != ARRAY_SETUP;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      avs_readdata <= '0;
    end else if (req.read && !ack_q) begin
      avs_readdata <= '0;
      unique case (req.address)
        CTRL_ADDR:   avs_readdata[ENABLE_BIT] <= flash_array_enable_bit_q;
        MODE_ADDR:   avs_readdata[1:0] <= mode_q;
        STATUS_ADDR: begin
          avs_readdata[READY_BIT]   <= state_q == ARRAY_READY;
          avs_readdata[SETUP_BIT]   <= state_q == ARRAY_SETUP;
          avs_readdata[STOP_OK_BIT] <= state_q != ARRAY_SETUP;
          avs_readdata[HOLD_OK_BIT] <= hold_cnt_q == 2'(HOLD_WAIT) &&
                                       dma_channel_hold_bit != '0;
        end
        HOLD_ADDR:   avs_readdata[DMA_CHANNELS-1:0] <= dma_channel_hold_bit;
        default: ;
      endcase
    end
  end

  // Assertion helper: length of the last setup and the mode it started in
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      setup_len_q  <= '0;
      setup_mode_q <= high_speed_main_mode;
    end else if (state_q == ARRAY_SETUP) begin
      setup_len_q  <= setup_len_q + CNT_W'(1);
    end else begin
      setup_len_q  <= '0;
      setup_mode_q <= mode_q;
    end
  end

  property p_stopped_no_read;
    @(posedge sys_clk) disable iff (reset)
      (state_q != ARRAY_READY) |=> !flash_read_grant;
  endproperty
  a_stopped_no_read: assert property (p_stopped_no_read)
    else $error("read granted before setup done");

  property p_enable_starts_setup;
    @(posedge sys_clk) disable iff (reset)
      (state_q == ARRAY_STOPPED && wr_en && req.address == CTRL_ADDR &&
       req.writedata[ENABLE_BIT]) |=> state_q == ARRAY_SETUP;
  endproperty
  a_enable_starts_setup: assert property (p_enable_starts_setup)
    else $error("enable did not start setup");

  property p_load_count;
    @(posedge sys_clk) disable iff (reset)
      (state_q == ARRAY_STOPPED && en_d && mode_q == low_speed_main_mode)
        |=> setup_cnt_q == CNT_W'(SETUP_LS_CYC);
  endproperty
  a_load_count: assert property (p_load_count)
    else $error("setup counter loaded wrongly");

  property p_ls_duration;
    @(posedge sys_clk) disable iff (reset)
      ($fell(state_q == ARRAY_SETUP) && state_q == ARRAY_READY) |->
        setup_len_q == CNT_W'(setup_mode_q == low_speed_main_mode    ? SETUP_LS_CYC :
                              setup_mode_q == low_voltage_main_mode ? SETUP_LV_CYC :
                                                                       SETUP_HS_CYC);
  endproperty
  a_ls_duration: assert property (p_ls_duration)
    else $error("setup length wrong for mode");

  property p_stop_blocked;
    @(posedge sys_clk) disable iff (reset)
      (state_q == ARRAY_SETUP) |=> !stop_accept;
  endproperty
  a_stop_blocked: assert property (p_stop_blocked)
    else $error("STOP accepted during setup");

  property p_disable_clears;
    @(posedge sys_clk) disable iff (reset)
      !en_d |=> state_q == ARRAY_STOPPED && setup_cnt_q == '0;
  endproperty
  a_disable_clears: assert property (p_disable_clears)
    else $error("disable did not clear setup");

  property p_store_never_granted;
    @(posedge sys_clk) disable iff (reset)
      cpu_flash_store |=> flash_store_blocked;
  endproperty
  a_store_never_granted: assert property (p_store_never_granted)
    else $error("plain store not blocked");

  property p_ready_reads;
    @(posedge sys_clk) disable iff (reset)
      (state_q == ARRAY_READY && cpu_flash_read) |=> flash_read_grant;
  endproperty
  a_ready_reads: assert property (p_ready_reads)
    else $error("ready array refused read");

  property p_hold_write;
    @(posedge sys_clk) disable iff (reset)
      (wr_en && req.address == HOLD_ADDR) |=>
        dma_channel_hold_bit == $past(req.writedata[DMA_CHANNELS-1:0]);
  endproperty
  a_hold_write: assert property (p_hold_write)
    else $error("hold bits not written");

  c_reach_ready: cover property (@(posedge sys_clk) state_q == ARRAY_READY);
  c_abort_setup: cover property (@(posedge sys_clk)
    state_q == ARRAY_SETUP ##1 state_q == ARRAY_STOPPED);
  c_stop_refused: cover property (@(posedge sys_clk)
    stop_request && state_q == ARRAY_SETUP);
endmodule

// ---- rtl/dflash_gate_pkg.sv ----
// Constants and types for the data flash access gate
package dflash_gate_pkg;
  localparam int CLK_MHZ         = 125;
  localparam int SETUP_HS_NS     = 5000;
  localparam int SETUP_LS_NS     = 720;
  localparam int SETUP_LV_NS     = 10000;
  localparam int SETUP_HS_CYC    = (SETUP_HS_NS * CLK_MHZ + 999) / 1000;
  localparam int SETUP_LS_CYC    = (SETUP_LS_NS * CLK_MHZ + 999) / 1000;
  localparam int SETUP_LV_CYC    = (SETUP_LV_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W           = 11;
  localparam int DMA_CHANNELS    = 2;

  localparam logic [3:0] CTRL_ADDR   = 4'h0;
  localparam logic [3:0] MODE_ADDR   = 4'h4;
  localparam logic [3:0] STATUS_ADDR = 4'h8;
  localparam logic [3:0] HOLD_ADDR   = 4'hC;

  localparam int ENABLE_BIT   = 0;
  localparam int READY_BIT    = 0;
  localparam int SETUP_BIT    = 1;
  localparam int STOP_OK_BIT  = 2;
  localparam int HOLD_OK_BIT  = 3;
  localparam int HOLD_WAIT    = 3;
  localparam logic [1:0] HOLD_CNT_W0 = 2'h0;

  typedef enum logic [1:0] {
    high_speed_main_mode  = 2'h0,
    low_speed_main_mode   = 2'h1,
    low_voltage_main_mode = 2'h2
  } flash_mode_t;

  typedef enum {ARRAY_STOPPED, ARRAY_SETUP, ARRAY_READY} array_state_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
  } avl_req_t;
endpackage

// ---- tb/data_flash_access_gate_tb.sv ----
// Self-checking bench for the data flash access gate
`timescale 1ns/1ps
module data_flash_access_gate_tb;
  import dflash_gate_pkg::*;
  logic                    sys_clk = 1'b0;
  logic                    reset = 1'b1;
  logic                    avs_read = 1'b0;
  logic                    avs_write = 1'b0;
  logic                    want_read = 1'b0;
  logic                    cpu_flash_store = 1'b0;
  logic                    stop_request = 1'b0;
  logic [3:0]              avs_address = 4'h0;
  logic [31:0]             avs_writedata = 32'h0;
  logic [31:0]             avs_readdata;
  logic [31:0]             rd;
  logic                    avs_waitrequest;
  logic                    cpu_flash_read;
  logic                    flash_read_grant;
  logic                    flash_store_blocked;
  logic                    stop_accept;
  logic [DMA_CHANNELS-1:0] dma_channel_hold_bit;
  logic [1:0]              h;
  int                      fails = 0;
  int                      checks = 0;
  int                      n;
  int                      cyc [3] = '{SETUP_HS_CYC, SETUP_LS_CYC, SETUP_LV_CYC};

  always #4 sys_clk = ~sys_clk;

  data_flash_access_gate u_dut (.sys_clk, .reset, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .cpu_flash_read, .cpu_flash_store,
    .stop_request, .flash_read_grant, .flash_store_blocked, .stop_accept,
    .dma_channel_hold_bit);
  flash_cpu_model u_cpu (.sys_clk, .reset, .want_read, .hold_bits(dma_channel_hold_bit),
    .cpu_flash_read);

  task automatic end_sim();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    for (i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 20) begin
      fails++;
      end_sim();
    end
    #1;
  endtask

  initial begin
    void'($urandom(32'hEAF37E91));
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    want_read <= 1'b1;
    stop_request <= 1'b1;
    cpu_flash_store <= 1'b1;
    bus(0, STATUS_ADDR, 32'h0);
    chk(rd[2:0], 3'h4);
    chk(flash_read_grant, 1'b0);
    chk(flash_store_blocked, 1'b1);
    bus(0, 4'h1 + 4'($urandom % 3), 32'h0);
    chk(rd, 32'h0);
    for (int m = 0; m < 3; m++) begin
      bus(1, MODE_ADDR, 32'(m));
      bus(1, CTRL_ADDR, 32'h1);
      for (n = 0; n < 2000 && flash_read_grant !== 1'b1; n++) begin
        @(posedge sys_clk);
        #1;
        if (n == 20) chk(stop_accept, 1'b0);
        if (n == 20) chk(flash_read_grant, 1'b0);
      end
      if (n == 2000) begin
        fails++;
        end_sim();
      end
      chk(n, cyc[m] + 1);
      bus(0, STATUS_ADDR, 32'h0);
      chk(rd[2:0], 3'h5);
      chk(stop_accept, 1'b1);
      h = 2'($urandom % 3) + 2'h1;
      bus(1, HOLD_ADDR, 32'(h));
      chk(dma_channel_hold_bit, h);
      repeat (2) @(posedge sys_clk);
      #1;
      chk(flash_read_grant, 1'b0);
      repeat (6) @(posedge sys_clk);
      #1;
      chk(flash_read_grant, 1'b1);
      bus(0, STATUS_ADDR, 32'h0);
      chk(rd[3], 1'b1);
      bus(1, HOLD_ADDR, 32'h0);
      chk(dma_channel_hold_bit, 2'h0);
      bus(1, CTRL_ADDR, 32'h0);
      bus(0, STATUS_ADDR, 32'h0);
      chk(rd[2:0], 3'h4);
    end
    bus(1, MODE_ADDR, 32'h2);
    bus(1, CTRL_ADDR, 32'h1);
    bus(0, STATUS_ADDR, 32'h0);
    chk(rd[2:0], 3'h2);
    bus(1, CTRL_ADDR, 32'h0);
    repeat (3) @(posedge sys_clk);
    #1;
    chk(stop_accept, 1'b1);
    chk(flash_read_grant, 1'b0);
    end_sim();
  end
endmodule

// ---- tb/flash_cpu_model.sv ----
// Behavioural CPU side that issues flash loads around the DMA hold bits
`timescale 1ns/1ps
module flash_cpu_model
  import dflash_gate_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic                    reset,
  input  wire logic                    want_read,
  input  wire logic [DMA_CHANNELS-1:0] hold_bits,
  output logic                         cpu_flash_read
);
  int wait_q;
  // A hold must stand three clocks so an in-flight DMA beat can drain
  always_ff @(posedge sys_clk) begin
    if (reset || hold_bits == '0) begin
      wait_q <= 0;
    end else if (wait_q < HOLD_WAIT) begin
      wait_q <= wait_q + 1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cpu_flash_read <= 1'b0;
    end else begin
      // Loads only; no rewrite is issued, so the fast oscillator never stops
      cpu_flash_read <= want_read && (hold_bits == '0 || wait_q >= HOLD_WAIT);
    end
  end
endmodule
